/* src/lsb_pkg.sv */
// Package for the logic, shift and bit-operation unit.
// Assumes a single clock domain; shared by the unit and its testbench.
package lsb_pkg;

  // ****************************************************************
  // Operand sizes.
  // ****************************************************************
  typedef enum logic [1:0] {
    LSB_SZ_BYTE = 2'h0, // Eight-bit operand.
    LSB_SZ_WORD = 2'h1, // Sixteen-bit operand.
    LSB_SZ_LONG = 2'h2  // Thirty-two-bit operand.
  } lsb_size_t;

  // ****************************************************************
  // Operation codes.
  // ****************************************************************
  typedef enum logic [4:0] {
    LSB_OP_AND = 5'h00, // Bitwise and.
    LSB_OP_OR = 5'h01, // Bitwise inclusive or.
    LSB_OP_XOR = 5'h02, // Bitwise exclusive or.
    LSB_OP_NOT = 5'h03, // One's complement.
    LSB_OP_ARITH_SHIFT_LEFT = 5'h04, // Arithmetic shift left.
    LSB_OP_ARITH_SHIFT_RIGHT = 5'h05, // Arithmetic shift right.
    LSB_OP_LOGIC_SHIFT_LEFT = 5'h06, // Logical shift left.
    LSB_OP_LOGIC_SHIFT_RIGHT = 5'h07, // Logical shift right.
    LSB_OP_ROTATE_LEFT = 5'h08, // Rotate left.
    LSB_OP_ROTATE_RIGHT = 5'h09, // Rotate right.
    LSB_OP_ROTATE_LEFT_VIA_CARRY = 5'h0A, // Rotate left via carry.
    LSB_OP_ROTATE_RIGHT_VIA_CARRY = 5'h0B, // Rotate right via carry.
    LSB_OP_SET_SELECTED_BIT = 5'h0C, // Force bit to one.
    LSB_OP_CLEAR_SELECTED_BIT = 5'h0D, // Force bit to zero.
    LSB_OP_INVERT_SELECTED_BIT = 5'h0E, // Complement bit.
    LSB_OP_TEST_SELECTED_BIT = 5'h0F, // Zero flag from bit.
    LSB_OP_CARRY_AND_BIT = 5'h10, // Carry and bit.
    LSB_OP_CARRY_AND_INVERTED_BIT = 5'h11, // Carry and not bit.
    LSB_OP_CARRY_OR_BIT = 5'h12, // Carry or bit.
    LSB_OP_CARRY_OR_INVERTED_BIT = 5'h13, // Carry or not bit.
    LSB_OP_CARRY_XOR_BIT = 5'h14, // Carry xor bit.
    LSB_OP_CARRY_XOR_INVERTED_BIT = 5'h15, // Carry xor not bit.
    LSB_OP_LOAD_BIT_TO_CARRY = 5'h16, // Bit to carry.
    LSB_OP_LOAD_INVERTED_BIT_TO_CARRY = 5'h17, // Not bit to carry.
    LSB_OP_STORE_CARRY_TO_BIT = 5'h18, // Carry to bit.
    LSB_OP_STORE_INVERTED_CARRY_TO_BIT = 5'h19 // Not carry to bit.
  } lsb_op_t;

  // ****************************************************************
  // Widths and reset values.
  // ****************************************************************
  localparam int LSB_DATA_W = 32; // Full register width.
  localparam int LSB_BITNO_W = 3; // Bit-number field width.
  localparam int LSB_BYTE_MSB = 7; // Sign bit of a byte.
  localparam int LSB_WORD_MSB = 15; // Sign bit of a word.
  localparam int LSB_LONG_MSB = 31; // Sign bit of a longword.
  localparam logic [31:0] LSB_RESULT_RST = 32'h0000_0000; // Result at reset.
  localparam logic LSB_FLAG_RST = 1'b0; // Flags at reset.

endpackage

/* src/lsb_bit_if.sv */
// Interface carrying one bit-select request and its answer.
// Assumes the unit drives the request side and the leaf the answer.
`timescale 1ns/1ps
interface lsb_bit_if;
  logic [7:0] byte_in; // Byte operand.
  logic [2:0] bit_no; // Selected bit number.
  logic bit_val; // Value of the selected bit.
  logic [7:0] one_hot; // Mask of the selected bit.

  // The unit asks with the byte and bit number.
  modport unit (output byte_in, output bit_no, input bit_val,
                input one_hot);
  // The leaf answers with the bit value and mask.
  modport leaf (input byte_in, input bit_no, output bit_val,
                output one_hot);
endinterface

/* src/lsb_bit_sel.sv */
// Bit-select leaf: picks one bit of a byte and builds its one-hot mask.
// Assumes purely combinational use by the unit on the same clock.
`timescale 1ns/1ps
module lsb_bit_sel (
  lsb_bit_if.leaf sel // Request and answer.
);

  // ****************************************************************
  // Selection.
  // ****************************************************************

  // Pure decode; no state, so the answer follows the request directly.
  always_comb begin
    sel.one_hot = 8'h01 << sel.bit_no;
    sel.bit_val = sel.byte_in[sel.bit_no];
  end

endmodule

/* src/lsb_unit.sv */
// Logic, shift, rotate and bit-manipulation execution unit.
// Assumes operands arrive already fetched and a one-cycle start pulse.
//
// What this block does
// - And destination with source or literal.
// - Or destination with source or literal.
// - Exclusive or destination with source or literal.
// - Complement every bit of destination.
// - Byte, word, longword sizes per operation.
// - Arithmetic shift left or right.
// - Logical shift left or right.
// - Rotate within width, end bit wraps.
// - Rotate through carry, carry gets out-bit.
// - Bit ops on bytes, number literal or register.
// - Inverted bit ops take literal number only.
// - Set forces one, clear forces zero.
// - Invert complements only the selected bit.
// - Test loads zero flag with inverted bit.
// - Carry becomes carry and bit.
// - Carry becomes carry and inverted bit.
// - Carry becomes carry or bit.
// - Carry becomes carry or inverted bit.
// - Carry becomes carry xor bit.
// - Carry becomes carry xor inverted bit.
// - Load bit or its inverse into carry.
// - Store carry or its inverse into bit.
// - Operands are 8, 16 or 32 bits.
`timescale 1ns/1ps
module lsb_unit (
  input wire logic CORE_CLK, // Processor clock, 40 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic START, // One-cycle request strobe.
  input wire lsb_pkg::lsb_op_t OP, // Operation to perform.
  input wire lsb_pkg::lsb_size_t SIZE, // Operand size.
  input wire logic [31:0] DEST, // Destination operand.
  input wire logic [31:0] SOURCE_REGISTER, // Second register operand.
  input wire logic [31:0] LITERAL_OPERAND, // Literal operand.
  input wire logic USE_LITERAL, // Pick literal over register.
  input wire logic [2:0] BIT_LITERAL, // Literal bit number.
  input wire logic CARRY_IN, // Current carry flag.
  input wire logic ZERO_IN, // Current zero flag.
  output logic DONE, // Result valid, one cycle.
  output logic ILLEGAL, // Request refused, one cycle.
  output logic [31:0] RESULT, // Value to write back.
  output logic WRITE_BACK, // Result must be written.
  output logic CARRY_OUT, // New carry flag.
  output logic ZERO_OUT // New zero flag.
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  lsb_bit_if bsel (); // Bit-select connection.
  logic [31:0] operand_b; // Register or literal second operand.
  logic [31:0] size_mask; // Ones over the active width.
  logic [31:0] logic_res; // Result of the combining stage.
  logic [31:0] result_d; // Next result.
  logic carry_d; // Next carry.
  logic zero_d; // Next zero flag.
  logic wb_d; // Next write-back strobe.
  logic illegal_d; // Request refused.
  logic msb_bit; // Top bit of the active width.
  logic lsb_bit; // Bottom bit.
  logic is_inverted; // Operation is an inverted bit variant.
  logic is_bit_op; // Operation works on a selected bit.
  logic [31:0] result_q; // Registered result.
  logic carry_q; // Registered carry.
  logic zero_q; // Registered zero flag.
  logic wb_q; // Registered write-back.
  logic done_q; // Registered done.
  logic illegal_q; // Registered refusal.

  // ****************************************************************
  // Bit selection.
  // ****************************************************************

  // Bit operations always work on the low byte of the operand.
  assign bsel.byte_in = DEST[lsb_pkg::LSB_BYTE_MSB:0];
  // Literal number or the low three bits of a register.
  assign bsel.bit_no = USE_LITERAL ? BIT_LITERAL :
    SOURCE_REGISTER[lsb_pkg::LSB_BITNO_W-1:0];

  lsb_bit_sel u_bit_sel (
    .sel (bsel.leaf)
  );

  // ****************************************************************
  // Operand shaping.
  // ****************************************************************

  // Width mask and end bits for the chosen size.
  always_comb begin
    operand_b = USE_LITERAL ? LITERAL_OPERAND : SOURCE_REGISTER;
    case (SIZE)
      lsb_pkg::LSB_SZ_BYTE: begin
        size_mask = 32'h0000_00FF;
        msb_bit = DEST[lsb_pkg::LSB_BYTE_MSB];
      end
      lsb_pkg::LSB_SZ_WORD: begin
        size_mask = 32'h0000_FFFF;
        msb_bit = DEST[lsb_pkg::LSB_WORD_MSB];
      end
      default: begin
        size_mask = 32'hFFFF_FFFF;
        msb_bit = DEST[lsb_pkg::LSB_LONG_MSB];
      end
    endcase
    lsb_bit = DEST[0];
  end

  // Inverted variants only accept a literal bit number.
  always_comb begin
    case (OP)
      lsb_pkg::LSB_OP_CARRY_AND_INVERTED_BIT,
      lsb_pkg::LSB_OP_CARRY_OR_INVERTED_BIT,
      lsb_pkg::LSB_OP_CARRY_XOR_INVERTED_BIT,
      lsb_pkg::LSB_OP_LOAD_INVERTED_BIT_TO_CARRY,
      lsb_pkg::LSB_OP_STORE_INVERTED_CARRY_TO_BIT: begin
        is_inverted = 1'b1;
      end
      default: begin
        is_inverted = 1'b0;
      end
    endcase
    is_bit_op = (OP >= lsb_pkg::LSB_OP_SET_SELECTED_BIT);
    // Refusal costs nothing in state and keeps flags intact.
    illegal_d = START && is_inverted && !USE_LITERAL;
  end

  // ****************************************************************
  // Main datapath.
  // ****************************************************************

  // One case per operation, the two left shifts sharing one; shifts move by exactly one place.
  always_comb begin
    logic_res = DEST;
    carry_d = CARRY_IN;
    zero_d = ZERO_IN;
    wb_d = 1'b1;
    case (OP)
      lsb_pkg::LSB_OP_AND: begin
        logic_res = DEST & operand_b;
      end
      lsb_pkg::LSB_OP_OR: begin
        logic_res = DEST | operand_b;
      end
      lsb_pkg::LSB_OP_XOR: begin
        logic_res = DEST ^ operand_b;
      end
      lsb_pkg::LSB_OP_NOT: begin
        logic_res = ~DEST;
      end
      lsb_pkg::LSB_OP_ARITH_SHIFT_LEFT,
      lsb_pkg::LSB_OP_LOGIC_SHIFT_LEFT: begin
        logic_res = {DEST[30:0], 1'b0};
        carry_d = msb_bit;
      end
      lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT: begin
        // Bits above the width are dropped first, or they would leak in.
        logic_res = ((DEST & size_mask) >> 1) |
          ({32{msb_bit}} & ~(size_mask >> 1));
        carry_d = lsb_bit;
      end
      lsb_pkg::LSB_OP_LOGIC_SHIFT_RIGHT: begin
        logic_res = (DEST & size_mask) >> 1;
        carry_d = lsb_bit;
      end
      lsb_pkg::LSB_OP_ROTATE_LEFT: begin
        logic_res = {DEST[30:0], msb_bit};
        carry_d = msb_bit;
      end
      lsb_pkg::LSB_OP_ROTATE_RIGHT: begin
        logic_res = ((DEST & size_mask) >> 1) |
          ({32{lsb_bit}} & ~(size_mask >> 1));
        carry_d = lsb_bit;
      end
      lsb_pkg::LSB_OP_ROTATE_LEFT_VIA_CARRY: begin
        logic_res = {DEST[30:0], CARRY_IN};
        carry_d = msb_bit;
      end
      lsb_pkg::LSB_OP_ROTATE_RIGHT_VIA_CARRY: begin
        logic_res = ((DEST & size_mask) >> 1) |
          ({32{CARRY_IN}} & ~(size_mask >> 1));
        carry_d = lsb_bit;
      end
      lsb_pkg::LSB_OP_SET_SELECTED_BIT: begin
        logic_res = DEST | {24'h00_0000, bsel.one_hot};
      end
      lsb_pkg::LSB_OP_CLEAR_SELECTED_BIT: begin
        logic_res = DEST & ~{24'h00_0000, bsel.one_hot};
      end
      lsb_pkg::LSB_OP_INVERT_SELECTED_BIT: begin
        logic_res = DEST ^ {24'h00_0000, bsel.one_hot};
      end
      lsb_pkg::LSB_OP_TEST_SELECTED_BIT: begin
        zero_d = ~bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_AND_BIT: begin
        carry_d = CARRY_IN & bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_AND_INVERTED_BIT: begin
        carry_d = CARRY_IN & ~bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_OR_BIT: begin
        carry_d = CARRY_IN | bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_OR_INVERTED_BIT: begin
        carry_d = CARRY_IN | ~bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_XOR_BIT: begin
        carry_d = CARRY_IN ^ bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_CARRY_XOR_INVERTED_BIT: begin
        carry_d = CARRY_IN ^ ~bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_LOAD_BIT_TO_CARRY: begin
        carry_d = bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_LOAD_INVERTED_BIT_TO_CARRY: begin
        carry_d = ~bsel.bit_val;
        wb_d = 1'b0;
      end
      lsb_pkg::LSB_OP_STORE_CARRY_TO_BIT: begin
        logic_res = CARRY_IN ? (DEST | {24'h00_0000, bsel.one_hot}) :
          (DEST & ~{24'h00_0000, bsel.one_hot});
      end
      lsb_pkg::LSB_OP_STORE_INVERTED_CARRY_TO_BIT: begin
        logic_res = !CARRY_IN ? (DEST | {24'h00_0000, bsel.one_hot}) :
          (DEST & ~{24'h00_0000, bsel.one_hot});
      end
      default: begin
        wb_d = 1'b0;
      end
    endcase
    // Bit ops are byte wide; others keep only the active width.
    result_d = logic_res & (is_bit_op ? 32'h0000_00FF : size_mask);
  end

  // ****************************************************************
  // Result registers.
  // ****************************************************************

  // The result and flags change only on an accepted request.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      result_q <= lsb_pkg::LSB_RESULT_RST;
      carry_q <= lsb_pkg::LSB_FLAG_RST;
      zero_q <= lsb_pkg::LSB_FLAG_RST;
    end else if (START && !illegal_d) begin
      result_q <= result_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
    end
  end

  // Strobes last one cycle after the request.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      done_q <= 1'b0;
      wb_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= START && !illegal_d;
      wb_q <= START && !illegal_d && wb_d;
      illegal_q <= illegal_d;
    end
  end

  assign RESULT = result_q;
  assign CARRY_OUT = carry_q;
  assign ZERO_OUT = zero_q;
  assign DONE = done_q;
  assign WRITE_BACK = wb_q;
  assign ILLEGAL = illegal_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Accepted request answered one cycle later.
  sequence s_accept;
    START && !illegal_d;
  endsequence

  chk_and_result: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_AND |=>
      RESULT == ($past(DEST) & $past(operand_b) & $past(size_mask)))
    else $error("and result wrong");

  chk_or_result: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_OR |=>
      RESULT == (($past(DEST) | $past(operand_b)) & $past(size_mask)))
    else $error("or result wrong");

  chk_not_result: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_NOT |=>
      RESULT == (~$past(DEST) & $past(size_mask)))
    else $error("not result wrong");

  chk_shift_carry: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_LOGIC_SHIFT_RIGHT |=>
      CARRY_OUT == $past(DEST[0]) && DONE)
    else $error("shift carry wrong");

  chk_rotx_carry: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_ROTATE_LEFT_VIA_CARRY |=>
      RESULT[0] == $past(CARRY_IN) && CARRY_OUT == $past(msb_bit))
    else $error("rotate via carry wrong");

  chk_test_zero: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_TEST_SELECTED_BIT |=>
      ZERO_OUT == !$past(bsel.bit_val) && !WRITE_BACK)
    else $error("test bit zero flag wrong");

  chk_carry_and: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_CARRY_AND_BIT |=>
      CARRY_OUT == ($past(CARRY_IN) & $past(bsel.bit_val)))
    else $error("carry and bit wrong");

  chk_inv_literal: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    START && is_inverted && !USE_LITERAL |=>
      ILLEGAL && !DONE && $stable(CARRY_OUT))
    else $error("inverted op with register number accepted");

  // Exclusive or over the active width.
  chk_xor_result: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_XOR |=>
      RESULT == (($past(DEST) ^ $past(operand_b)) & $past(size_mask)))
    else $error("xor result wrong");

  // A byte shifted right keeps its sign and ignores the bits above it.
  chk_asr_sign: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT
      and SIZE == lsb_pkg::LSB_SZ_BYTE |=>
      RESULT == {24'h00_0000, $past(DEST[lsb_pkg::LSB_BYTE_MSB]),
        $past(DEST[lsb_pkg::LSB_BYTE_MSB:1])})
    else $error("arithmetic right shift wrong");

  // The selected bit reads one after a set and is written back.
  chk_set_bit: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_accept and OP == lsb_pkg::LSB_OP_SET_SELECTED_BIT |=>
      (RESULT[lsb_pkg::LSB_BYTE_MSB:0] & $past(bsel.one_hot)) != 8'h00
      && WRITE_BACK)
    else $error("set bit not forced to one");

endmodule

/* sim/lsb_unit_tb.sv */
// Self-checking bench for the logic, shift and bit-operation unit.
// Assumes the unit answers one cycle after START and holds its flags.
`timescale 1ns/1ps
module lsb_unit_tb;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic core_clk = 1'b0; // Bench clock, 25 ns period.
  logic rst = 1'b1; // Reset, held at start.
  logic start = 1'b0; // Request strobe.
  lsb_pkg::lsb_op_t op = lsb_pkg::LSB_OP_AND; // Operation code.
  lsb_pkg::lsb_size_t size = lsb_pkg::LSB_SZ_BYTE; // Operand size.
  logic [31:0] dest = 32'h0000_0000; // Destination operand.
  logic [31:0] src = 32'h0000_0000; // Register operand.
  logic [31:0] lit = 32'h0000_0000; // Literal operand.
  logic use_lit = 1'b0; // Literal select.
  logic [2:0] bit_lit = 3'h0; // Literal bit number.
  logic cin = 1'b0; // Carry flag in.
  logic zin = 1'b0; // Zero flag in.
  logic done, illegal, write_back, carry_out, zero_out; // Unit answers.
  logic [31:0] result; // Unit result.
  // Model state: what the unit should show after the next edge.
  logic e_done, e_ill, e_wb, e_c, e_z, last_c, last_z, res_known;
  logic [31:0] e_res, last_res, rnd;
  int err_count = 0; // Mismatches seen.
  int compares = 0; // Comparisons made.

  always #12.5 core_clk = ~core_clk; // Forty megahertz.

  lsb_unit u_dut (.CORE_CLK(core_clk), .RST(rst), .START(start), .OP(op),
    .SIZE(size), .DEST(dest), .SOURCE_REGISTER(src),
    .LITERAL_OPERAND(lit), .USE_LITERAL(use_lit), .BIT_LITERAL(bit_lit),
    .CARRY_IN(cin), .ZERO_IN(zin), .DONE(done), .ILLEGAL(illegal),
    .RESULT(result), .WRITE_BACK(write_back), .CARRY_OUT(carry_out),
    .ZERO_OUT(zero_out));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Galois shift register, so every run sees the same operands.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction

  // One comparison; an unknown never passes for a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Clears the model to the state the unit shows out of reset.
  task automatic model_reset();
    {e_done, e_ill, e_wb, e_c, e_z, last_c, last_z} = 7'h00;
    e_res = 32'h0000_0000;
    last_res = 32'h0000_0000;
    res_known = 1'b1;
  endtask

  // ****************************************************************
  // Reference model, run as each request is driven.
  // ****************************************************************
  task automatic model();
    logic [31:0] m, d, r, one;
    int w, n;
    logic bv;
    e_done = start;
    e_ill = 1'b0;
    e_wb = 1'b0;
    e_c = last_c;
    e_z = last_z;
    r = last_res;
    // Inverted bit ops name their bit only by literal; else refused.
    if (start && !use_lit && (op inside {5'h11, 5'h13, 5'h15, 5'h17,
        5'h19})) begin
      e_done = 1'b0;
      e_ill = 1'b1;
    end else if (start) begin
      w = (size == lsb_pkg::LSB_SZ_BYTE) ? 8 :
          (size == lsb_pkg::LSB_SZ_WORD) ? 16 : 32;
      m = (w == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << w) - 32'h0000_0001;
      d = dest & m;
      n = use_lit ? int'(bit_lit) : int'(src[2:0]);
      one = 32'h0000_0001 << n;
      bv = dest[n];
      e_c = cin;
      e_z = zin;
      e_wb = 1'b1;
      case (op)
        lsb_pkg::LSB_OP_AND: r = d & (use_lit ? lit : src);
        lsb_pkg::LSB_OP_OR: r = (d | (use_lit ? lit : src)) & m;
        lsb_pkg::LSB_OP_XOR: r = (d ^ (use_lit ? lit : src)) & m;
        lsb_pkg::LSB_OP_NOT: r = ~d & m;
        lsb_pkg::LSB_OP_ARITH_SHIFT_LEFT,
        lsb_pkg::LSB_OP_LOGIC_SHIFT_LEFT: r = (d << 1) & m;
        lsb_pkg::LSB_OP_ARITH_SHIFT_RIGHT: r = (d >> 1) | (d & (m ^ (m >> 1)));
        lsb_pkg::LSB_OP_LOGIC_SHIFT_RIGHT: r = d >> 1;
        lsb_pkg::LSB_OP_ROTATE_LEFT: r = ((d << 1) | 32'(d[w-1])) & m;
        lsb_pkg::LSB_OP_ROTATE_RIGHT: r = (d >> 1) | (32'(d[0]) << (w-1));
        lsb_pkg::LSB_OP_ROTATE_LEFT_VIA_CARRY: r = ((d << 1) | 32'(cin)) & m;
        lsb_pkg::LSB_OP_ROTATE_RIGHT_VIA_CARRY: r = (d >> 1) | (32'(cin) << (w-1));
        lsb_pkg::LSB_OP_SET_SELECTED_BIT: r = 32'(dest[7:0]) | one;
        lsb_pkg::LSB_OP_CLEAR_SELECTED_BIT: r = 32'(dest[7:0]) & ~one;
        lsb_pkg::LSB_OP_INVERT_SELECTED_BIT: r = 32'(dest[7:0]) ^ one;
        lsb_pkg::LSB_OP_STORE_CARRY_TO_BIT: r = (32'(dest[7:0]) & ~one) |
          (cin ? one : 32'h0000_0000);
        lsb_pkg::LSB_OP_STORE_INVERTED_CARRY_TO_BIT: r = (32'(dest[7:0]) &
          ~one) | (cin ? 32'h0000_0000 : one);
        default: e_wb = 1'b0;
      endcase
      // Shifts and rotates hand the bit that leaves the operand to carry.
      if (op inside {5'h04, 5'h06, 5'h08, 5'h0A}) e_c = d[w-1];
      if (op inside {5'h05, 5'h07, 5'h09, 5'h0B}) e_c = d[0];
      if (op == lsb_pkg::LSB_OP_TEST_SELECTED_BIT) e_z = ~bv;
      if (op == lsb_pkg::LSB_OP_CARRY_AND_BIT) e_c = cin & bv;
      if (op == lsb_pkg::LSB_OP_CARRY_AND_INVERTED_BIT) e_c = cin & ~bv;
      if (op == lsb_pkg::LSB_OP_CARRY_OR_BIT) e_c = cin | bv;
      if (op == lsb_pkg::LSB_OP_CARRY_OR_INVERTED_BIT) e_c = cin | ~bv;
      if (op == lsb_pkg::LSB_OP_CARRY_XOR_BIT) e_c = cin ^ bv;
      if (op == lsb_pkg::LSB_OP_CARRY_XOR_INVERTED_BIT) e_c = cin ^ ~bv;
      if (op == lsb_pkg::LSB_OP_LOAD_BIT_TO_CARRY) e_c = bv;
      if (op == lsb_pkg::LSB_OP_LOAD_INVERTED_BIT_TO_CARRY) e_c = ~bv;
      // Without a write-back the held result is left to the design.
      res_known = e_wb;
    end
    e_res = r;
    last_res = r;
    last_c = e_c;
    last_z = e_z;
  endtask

  // ****************************************************************
  // One cycle: check the previous answer, then drive the next request.
  // ****************************************************************
  task automatic step(input logic go, input logic [4:0] code,
                      input logic [1:0] sz);
    @(posedge core_clk);
    #1;
    chk(done, e_done);
    chk(illegal, e_ill);
    chk(write_back, e_wb);
    if (res_known && op < 5'h04) chk(result, e_res);
    else if (res_known && op < 5'h0C) chk(result, e_res);
    else if (res_known) chk(result, e_res);
    chk(carry_out, e_c);
    chk(zero_out, e_z);
    rnd = lfsr(rnd);
    dest = rnd;
    rnd = lfsr(rnd);
    src = rnd;
    rnd = lfsr(rnd);
    lit = rnd;
    {use_lit, bit_lit, cin, zin} = rnd[5:0];
    start = go;
    op = lsb_pkg::lsb_op_t'(code);
    size = lsb_pkg::lsb_size_t'(sz);
    model();
  endtask

  // ****************************************************************
  // Main sequence: every code at every size, back to back or spaced.
  // ****************************************************************
  initial begin
    rnd = 32'h0001_2FC7;
    model_reset();
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      for (int o = 0; o < 27; o++) begin
        for (int s = 0; s < 4; s++) begin
          // An idle cycle now and then proves outputs hold.
          if (rnd[9:8] == 2'h0) step(1'b0, 5'h00, 2'h0);
          step(1'b1, (o == 26) ? 5'h1F : 5'(o), 2'(s));
        end
      end
      // A reset in mid-run clears everything at once.
      if (k == 3) begin
        // Collect the last answer before reset wipes it.
        step(1'b0, 5'h00, 2'h0);
        rst = 1'b1;
        #1;
        chk({done, illegal, write_back, carry_out, zero_out}, 32'h0000_0000);
        chk(result, 32'h0000_0000);
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        model_reset();
      end
    end
    step(1'b0, 5'h00, 2'h0);
    print_verdict();
  end

  // Watchdog: the run needs about 1100 cycles; allow 5000.
  initial begin
    #(25 * 5000);
    err_count++;
    print_verdict();
  end
endmodule
